// *** hdl/drs_pkg.sv ***
`default_nettype none
package drs_pkg;
  // ===========================================
  // frame layout
  localparam int FRAME_BITS = 24;
  localparam int INSTR_MSB = 23;
  localparam int INSTR_LSB = 20;
  localparam int ADDR_MSB = 19;
  localparam int ADDR_LSB = 16;
  localparam int PAYLOAD_MSB = 15;
  localparam int WIPER_BITS = 10;
  localparam int STORE_WORDS = 16;
  // ===========================================
  // values
  localparam logic [9:0] WIPER_MID = 10'h200;
  localparam logic [9:0] WIPER_FULL = 10'h3ff;
  localparam logic [15:0] STORE_RESET = 16'h0200;
  // ===========================================
  // timing
  localparam int CLK_MHZ = 100;
  localparam int SAVE_TIME_MS = 25;
  localparam int SAVE_CYCLES = SAVE_TIME_MS * 1000 * CLK_MHZ;
  // ===========================================
  // instructions
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_RESTORE = 4'h1;
  localparam logic [3:0] OP_SAVE = 4'h2;
  localparam logic [3:0] OP_WRSTORE = 4'h3;
  localparam logic [3:0] OP_SHR = 4'h4;
  localparam logic [3:0] OP_SHR_ALL = 4'h5;
  localparam logic [3:0] OP_DEC = 4'h6;
  localparam logic [3:0] OP_DEC_ALL = 4'h7;
  localparam logic [3:0] OP_RELOAD = 4'h8;
  localparam logic [3:0] OP_RD_STORE = 4'h9;
  localparam logic [3:0] OP_RD_WIPER = 4'ha;
  localparam logic [3:0] OP_WR_WIPER = 4'hb;
  localparam logic [3:0] OP_SHL = 4'hc;
  localparam logic [3:0] OP_SHL_ALL = 4'hd;
  localparam logic [3:0] OP_INC = 4'he;
  localparam logic [3:0] OP_INC_ALL = 4'hf;
endpackage : drs_pkg
`default_nettype wire

// *** hdl/drs_store_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
// ===========================================
// nonvolatile store model, registered read
module drs_store_mem #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic we_i,
  input wire logic [3:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic [3:0] raddr_i,
  output logic [WIDTH-1:0] rdata_o
);
  // storage; reset stands in for factory contents
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] rdata_reg;

  assign rdata_o = rdata_reg;

  // write port and registered read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= WIDTH'(drs_pkg::STORE_RESET);
      end
      rdata_reg <= '0;
    end else begin
      if (we_i) begin
        mem_reg[waddr_i] <= wdata_i;
      end
      rdata_reg <= mem_reg[raddr_i];
    end
  end
endmodule : drs_store_mem
`default_nettype wire

// *** hdl/drs_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none
// ===========================================
// serial command decoder for a dual wiper device
module drs_decoder #(
  parameter int SAVE_CYCLES = drs_pkg::SAVE_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic serial_clk_i,
  input wire logic serial_in_pin_i,
  input wire logic chip_sel_n_i,
  input wire logic write_protect_n_i,
  input wire logic preset_reload_pin_n_i,
  output logic serial_out_pin_o,
  output logic ready_o,
  output logic read_power_o,
  output logic [9:0] wiper0_o,
  output logic [9:0] wiper1_o
);
  // ===========================================
  // pin synchronisers, two flops each
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] prev_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // idle levels: serial clock parks low, the rest sit high
      sync1_reg <= 4'hb;
      sync2_reg <= 4'hb;
      prev_reg <= 4'hb;
    end else begin
      sync1_reg <= {preset_reload_pin_n_i, serial_clk_i, chip_sel_n_i, write_protect_n_i};
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end
  logic wp_n;
  logic cs_n;
  logic sclk;
  logic pr_n;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  logic pr_fall;
  logic pr_rise;
  assign wp_n = sync2_reg[0];
  assign cs_n = sync2_reg[1];
  assign sclk = sync2_reg[2];
  assign pr_n = sync2_reg[3];
  assign sclk_rise = sclk & ~prev_reg[2];
  assign sclk_fall = ~sclk & prev_reg[2];
  assign cs_rise = cs_n & ~prev_reg[1];
  assign pr_fall = ~pr_n & prev_reg[3];
  assign pr_rise = pr_n & ~prev_reg[3];

  // ===========================================
  // sequencer states
  typedef enum logic [4:0] {
    ST_BOOT = 5'b00001,
    ST_IDLE = 5'b00010,
    ST_FETCH = 5'b00100,
    ST_APPLY = 5'b01000,
    ST_SAVE = 5'b10000
  } drs_state_t;

  drs_state_t state_reg, state_next;
  logic [23:0] shift_reg, shift_next;   // serial shifter
  logic out_reg, out_next;              // serial out bit
  logic [9:0] wiper_reg [2];            // wiper_setting_reg per channel
  logic [9:0] wiper_next [2];
  logic [3:0] op_reg, op_next;          // latched instruction
  logic [3:0] addr_reg, addr_next;      // latched address
  logic [15:0] data_reg, data_next;     // latched payload
  logic ready_reg, ready_next;
  logic rdp_reg, rdp_next;              // read power state
  logic midscale_reg, midscale_next;    // preset pin held low
  logic [1:0] boot_reg, boot_next;      // boot load index
  logic [31:0] cnt_reg, cnt_next;       // save timer
  logic mem_we;
  logic [3:0] mem_waddr;
  logic [15:0] mem_wdata;
  logic [3:0] mem_raddr;
  logic [15:0] mem_rdata;
  logic [1:0] sdi_sync_reg;             // data pin synchroniser
  logic serial_in_pin_i_s;              // synchronised data bit

  drs_store_mem #(.DEPTH(drs_pkg::STORE_WORDS), .WIDTH(16)) u_store (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .we_i(mem_we),
    .waddr_i(mem_waddr),
    .wdata_i(mem_wdata),
    .raddr_i(mem_raddr),
    .rdata_o(mem_rdata)
  );

  // saturating step of one wiper for a step opcode
  function automatic logic [9:0] step_wiper(input logic [3:0] op, input logic [9:0] w);
    logic [9:0] r;
    r = w;
    case (op)
      drs_pkg::OP_SHR, drs_pkg::OP_SHR_ALL: r = {1'b0, w[9:1]};
      drs_pkg::OP_DEC, drs_pkg::OP_DEC_ALL: r = (w == 10'h000) ? w : w - 10'h001;
      drs_pkg::OP_SHL, drs_pkg::OP_SHL_ALL: begin
        if (w == 10'h000) begin
          r = 10'h001;
        end else if (w >= drs_pkg::WIPER_MID) begin
          r = drs_pkg::WIPER_FULL;
        end else begin
          r = {w[8:0], 1'b0};
        end
      end
      drs_pkg::OP_INC, drs_pkg::OP_INC_ALL: r = (w == drs_pkg::WIPER_FULL) ? w : w + 10'h001;
      default: r = w;
    endcase
    return r;
  endfunction : step_wiper

  // true for opcodes that act on both channels
  function automatic logic is_gang(input logic [3:0] op);
    return op == drs_pkg::OP_SHR_ALL || op == drs_pkg::OP_DEC_ALL ||
           op == drs_pkg::OP_SHL_ALL || op == drs_pkg::OP_INC_ALL;
  endfunction : is_gang

  // ===========================================
  // next-state logic
  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    out_next = out_reg;
    wiper_next[0] = wiper_reg[0];
    wiper_next[1] = wiper_reg[1];
    op_next = op_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    ready_next = ready_reg;
    rdp_next = rdp_reg;
    midscale_next = midscale_reg;
    boot_next = boot_reg;
    cnt_next = cnt_reg;
    mem_we = 1'b0;
    mem_waddr = addr_reg;
    mem_wdata = data_reg;
    mem_raddr = addr_reg;
    if (pr_fall) begin
      midscale_next = 1'b1;
    end
    // shifter locked during save; msb first
    if (!cs_n && state_reg != drs_state_t'(ST_SAVE) && state_reg != drs_state_t'(ST_BOOT)) begin
      if (sclk_rise) begin
        shift_next = {shift_reg[22:0], serial_in_pin_i_s};
      end
      if (sclk_fall) begin
        out_next = shift_reg[23];
      end
    end
    case (state_reg)
      ST_BOOT: begin
        mem_raddr = {2'b00, boot_reg};
        boot_next = boot_reg + 2'd1;
        if (boot_reg == 2'd1) begin
          wiper_next[0] = mem_rdata[9:0];
        end
        if (boot_reg == 2'd2) begin
          wiper_next[1] = mem_rdata[9:0];
          ready_next = 1'b1;
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (midscale_reg) begin
          wiper_next[0] = drs_pkg::WIPER_MID;
          wiper_next[1] = drs_pkg::WIPER_MID;
          if (pr_rise) begin
            midscale_next = 1'b0;
            ready_next = 1'b0;
            boot_next = 2'd0;
            state_next = ST_BOOT;
          end
        end else if (cs_rise) begin
          op_next = shift_reg[drs_pkg::INSTR_MSB:drs_pkg::INSTR_LSB];
          addr_next = shift_reg[drs_pkg::ADDR_MSB:drs_pkg::ADDR_LSB];
          data_next = shift_reg[drs_pkg::PAYLOAD_MSB:0];
          state_next = ST_FETCH;
        end
      end
      ST_FETCH: begin
        // channel bit only for wiper ops
        mem_raddr = (op_reg == drs_pkg::OP_RD_STORE) ? addr_reg : {3'b000, addr_reg[0]};
        state_next = ST_APPLY;
      end
      ST_APPLY: begin
        state_next = ST_IDLE;
        case (op_reg)
          drs_pkg::OP_NOP: rdp_next = 1'b0;
          drs_pkg::OP_RESTORE: begin
            wiper_next[addr_reg[0]] = mem_rdata[9:0];
            rdp_next = 1'b1;
          end
          drs_pkg::OP_RELOAD: begin
            ready_next = 1'b0;
            boot_next = 2'd0;
            state_next = ST_BOOT;
          end
          drs_pkg::OP_RD_STORE: begin
            shift_next[15:0] = mem_rdata;
            ready_next = 1'b1;
          end
          // wiper readback; lands in data bytes
          drs_pkg::OP_RD_WIPER: begin
            shift_next[15:0] = {6'h00, wiper_reg[addr_reg[0]]};
            ready_next = 1'b1;
          end
          default: begin
            if (wp_n) begin
              case (op_reg)
                drs_pkg::OP_SAVE: begin
                  mem_we = 1'b1;
                  mem_waddr = {3'b000, addr_reg[0]};
                  mem_wdata = {6'h00, wiper_reg[addr_reg[0]]};
                  ready_next = 1'b0;
                  cnt_next = '0;
                  state_next = ST_SAVE;
                end
                drs_pkg::OP_WRSTORE: begin
                  // full payload; ten bits at 0,1
                  mem_we = 1'b1;
                  mem_waddr = addr_reg;
                  mem_wdata = (addr_reg[3:1] == 3'b000) ? {6'h00, data_reg[9:0]} : data_reg;
                  ready_next = 1'b0;
                  cnt_next = '0;
                  state_next = ST_SAVE;
                end
                drs_pkg::OP_WR_WIPER: wiper_next[addr_reg[0]] = data_reg[9:0];
                default: begin
                  if (is_gang(op_reg)) begin
                    wiper_next[0] = step_wiper(op_reg, wiper_reg[0]);
                    wiper_next[1] = step_wiper(op_reg, wiper_reg[1]);
                  end else begin
                    wiper_next[addr_reg[0]] = step_wiper(op_reg, wiper_reg[addr_reg[0]]);
                  end
                end
              endcase
            end
          end
        endcase
      end
      ST_SAVE: begin
        cnt_next = cnt_reg + 32'd1;
        if (cnt_reg == 32'(SAVE_CYCLES - 1)) begin
          ready_next = 1'b1;
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // data pin sampled through its own two flops
  assign serial_in_pin_i_s = sdi_sync_reg[1];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sdi_sync_reg <= 2'b00;
    end else begin
      sdi_sync_reg <= {sdi_sync_reg[0], serial_in_pin_i};
    end
  end

  // ===========================================
  // registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_BOOT;
      shift_reg <= '0;
      out_reg <= 1'b0;
      wiper_reg[0] <= drs_pkg::WIPER_MID;
      wiper_reg[1] <= drs_pkg::WIPER_MID;
      op_reg <= drs_pkg::OP_NOP;
      addr_reg <= 4'h0;
      data_reg <= 16'h0000;
      ready_reg <= 1'b0;
      rdp_reg <= 1'b0;
      midscale_reg <= 1'b0;
      boot_reg <= 2'd0;
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      out_reg <= out_next;
      wiper_reg[0] <= wiper_next[0];
      wiper_reg[1] <= wiper_next[1];
      op_reg <= op_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      ready_reg <= ready_next;
      rdp_reg <= rdp_next;
      midscale_reg <= midscale_next;
      boot_reg <= boot_next;
      cnt_reg <= cnt_next;
    end
  end

  assign serial_out_pin_o = out_reg;
  assign ready_o = ready_reg;
  assign read_power_o = rdp_reg;
  assign wiper0_o = wiper_reg[0];
  assign wiper1_o = wiper_reg[1];
endmodule : drs_decoder
`default_nettype wire

// *** testbench/drs_props.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========
// port checker for the command decoder
module drs_props #(
  parameter int SAVE_CYCLES = 20
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic serial_clk_i,
  input wire logic serial_in_pin_i,
  input wire logic chip_sel_n_i,
  input wire logic write_protect_n_i,
  input wire logic preset_reload_pin_n_i,
  input wire logic serial_out_pin_o,
  input wire logic ready_o,
  input wire logic read_power_o,
  input wire logic [9:0] wiper0_o,
  input wire logic [9:0] wiper1_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // cycles spent with ready low, so a stuck save is seen
  int unsigned low_cnt;
  always_ff @(posedge clk_i) begin
    if (rst_i || ready_o) begin
      low_cnt <= 0;
    end else begin
      low_cnt <= low_cnt + 1;
    end
  end
  property p_exec_cs;
    (!chip_sel_n_i && preset_reload_pin_n_i) [*8] |-> $stable(wiper0_o) && $stable(wiper1_o);
  endproperty
  a_exec_cs: assert property (p_exec_cs) else $error("wiper moved inside a frame");
  property p_rp_cs;
    (!chip_sel_n_i) [*8] |-> $stable(read_power_o);
  endproperty
  a_rp_cs: assert property (p_rp_cs) else $error("power state moved inside a frame");
  property p_preset_mid;
    (!preset_reload_pin_n_i) [*6] |-> wiper0_o == 10'h200 && wiper1_o == 10'h200;
  endproperty
  a_preset_mid: assert property (p_preset_mid) else $error("preset low without midscale");
  property p_preset_done;
    $rose(preset_reload_pin_n_i) |-> ##[2:6] !ready_o ##[1:10] ready_o;
  endproperty
  a_preset_done: assert property (p_preset_done) else $error("preset reload never ready");
  property p_sdo_edge;
    $changed(serial_out_pin_o) |-> !serial_clk_i && !chip_sel_n_i;
  endproperty
  a_sdo_edge: assert property (p_sdo_edge) else $error("serial out moved off the falling edge");
  property p_rdy_fall;
    $fell(ready_o) |-> chip_sel_n_i;
  endproperty
  a_rdy_fall: assert property (p_rdy_fall) else $error("ready dropped inside a frame");
  property p_save_len;
    low_cnt <= SAVE_CYCLES + 16;
  endproperty
  a_save_len: assert property (p_save_len) else $error("ready low too long");
  property p_boot;
    $fell(rst_i) |-> ##[0:10] ready_o && wiper0_o == 10'h200 && wiper1_o == 10'h200;
  endproperty
  a_boot: assert property (p_boot) else $error("no load from store after reset");
endmodule : drs_props
`default_nettype wire

// *** testbench/drs_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========
// serial master standing in for the host
module drs_host (
  output logic serial_clk_o,
  output logic serial_in_o,
  output logic chip_sel_n_o,
  input wire logic serial_out_i
);
  // clock parks low between frames
  initial begin
    serial_clk_o = 1'b0;
    serial_in_o = 1'b0;
    chip_sel_n_o = 1'b1;
  end
  // one frame out, reply bit taken just before each rising edge
  task automatic xfer(input logic [23:0] w, output logic [23:0] r);
    // step off the system clock edge the caller returned on
    #1 chip_sel_n_o = 1'b0;
    #62.5;
    for (int i = 23; i >= 0; i--) begin
      // output moved on the previous falling edge, so it is settled here
      r[i] = serial_out_i;
      serial_in_o = w[i];
      #2.5 serial_clk_o = 1'b1;
      #62.5 serial_clk_o = 1'b0;
      #60;
    end
    chip_sel_n_o = 1'b1;
    serial_in_o = ~w[0];
  endtask : xfer
endmodule : drs_host
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========
// bench top
module tb_top;
  localparam int SAVE_N = 400;
  logic clk_i, rst_i, wp_n, pr_n, sclk, serial_in_pin, cs_n, serial_out_pin, rdy, rp;
  logic [9:0] w0, w1;
  logic [23:0] rx;
  int fails, checks;
  drs_decoder #(.SAVE_CYCLES(SAVE_N)) DUT (.clk_i(clk_i), .rst_i(rst_i),
    .serial_clk_i(sclk), .serial_in_pin_i(serial_in_pin), .chip_sel_n_i(cs_n),
    .write_protect_n_i(wp_n), .preset_reload_pin_n_i(pr_n), .serial_out_pin_o(serial_out_pin),
    .ready_o(rdy), .read_power_o(rp), .wiper0_o(w0), .wiper1_o(w1));
  drs_host host (.serial_clk_o(sclk), .serial_in_o(serial_in_pin), .chip_sel_n_o(cs_n),
    .serial_out_i(serial_out_pin));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  // one command, then let the decoder settle
  task automatic cmd(input logic [3:0] op, input logic [3:0] a, input logic [15:0] d);
    host.xfer({op, a, d}, rx);
    repeat (20) @(posedge clk_i);
  endtask : cmd
  // bounded wait, long enough for a full save
  task automatic wait_rdy;
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 1000) begin
      @(posedge clk_i);
      n++;
    end
    check(24'(rdy), 24'h1);
  endtask : wait_rdy
  function automatic logic [9:0] step(input logic [3:0] op, input logic [9:0] v);
    case (op)
      4'h4, 4'h5: step = v >> 1;
      4'h6, 4'h7: step = (v == 10'h000) ? v : v - 10'h001;
      4'hc, 4'hd: step = (v == 10'h000) ? 10'h001 : (v >= 10'h200) ? 10'h3ff : v << 1;
      default: step = (v == 10'h3ff) ? v : v + 10'h001;
    endcase
  endfunction : step
  task automatic t_write;
    wait_rdy;
    check(24'({w1, w0}), 24'h80200);
    cmd(4'hb, 4'h0, 16'hfd55);
    check(24'({w1, w0}), 24'h80155);
    cmd(4'h0, 4'h7, 16'h1234);
    check(rx, 24'hb0fd55);
    check(24'({w1, w0}), 24'h80155);
  endtask : t_write
  // floors, saturation and gang moves, data bytes all ones
  task automatic t_steps;
    logic [3:0] ops [13] = '{4'h6, 4'h4, 4'hc, 4'he, 4'hc, 4'hc, 4'he, 4'hf, 4'hd, 4'h5,
      4'h7, 4'h6, 4'h4};
    logic [3:0] adr [13] = '{4'h1, 4'h1, 4'h1, 4'h0, 4'h0, 4'h0, 4'h0, 4'hf, 4'h3, 4'ha,
      4'h5, 4'h0, 4'h0};
    logic [9:0] e0, e1;
    cmd(4'hb, 4'h1, 16'h0000);
    e0 = 10'h155;
    e1 = 10'h000;
    for (int i = 0; i < 13; i++) begin
      cmd(ops[i], adr[i], 16'hffff);
      if (ops[i][0] || !adr[i][0]) e0 = step(ops[i], e0);
      if (ops[i][0] || adr[i][0]) e1 = step(ops[i], e1);
      check(24'({w1, w0}), 24'({e1, e0}));
    end
  endtask : t_steps
  task automatic t_save;
    cmd(4'hb, 4'h1, 16'h00f0);
    cmd(4'h2, 4'h1, 16'h0000);
    check(24'(rdy), 24'h0);
    cmd(4'hb, 4'h1, 16'h0033);
    check(24'(w1), 24'h0f0);
    wait_rdy;
    cmd(4'hb, 4'h1, 16'h0011);
    cmd(4'h8, 4'ha, 16'h0000);
    wait_rdy;
    check(24'({w1, w0}), 24'h3c200);
  endtask : t_save
  task automatic t_store;
    cmd(4'h3, 4'h5, 16'hbeef);
    wait_rdy;
    cmd(4'h9, 4'h5, 16'h0000);
    wait_rdy;
    cmd(4'h0, 4'h0, 16'h0000);
    check(24'(rx[15:0]), 24'hbeef);
    cmd(4'h3, 4'h0, 16'hfc33);
    wait_rdy;
    cmd(4'h1, 4'h0, 16'h0000);
    check(24'(w0), 24'h033);
    check(24'(rp), 24'h1);
    cmd(4'h0, 4'h0, 16'h0000);
    check(24'(rp), 24'h0);
    cmd(4'ha, 4'h1, 16'h0000);
    wait_rdy;
    cmd(4'h0, 4'h0, 16'h0000);
    check(24'(rx[15:0]), 24'h00f0);
  endtask : t_store
  task automatic t_protect;
    cmd(4'hb, 4'h1, 16'h0001);
    wp_n <= 1'b0;
    cmd(4'hb, 4'h0, 16'h0155);
    check(24'(w0), 24'h033);
    cmd(4'h1, 4'h1, 16'h0000);
    check(24'(w1), 24'h0f0);
    cmd(4'h0, 4'h0, 16'h0000);
    wp_n <= 1'b1;
  endtask : t_protect
  task automatic t_preset;
    pr_n <= 1'b0;
    repeat (10) @(posedge clk_i);
    check(24'({w1, w0}), 24'h80200);
    pr_n <= 1'b1;
    repeat (10) @(posedge clk_i);
    wait_rdy;
    check(24'({w1, w0}), 24'h3c033);
  endtask : t_preset
  // hang guard, well past the expected run
  initial begin
    #500us;
    fails++;
    report_and_stop;
  end
  initial begin
    rst_i = 1'b1;
    wp_n = 1'b1;
    pr_n = 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_write;
    t_steps;
    t_save;
    t_store;
    t_protect;
    t_preset;
    report_and_stop;
  end
endmodule : tb_top
bind drs_decoder drs_props #(.SAVE_CYCLES(SAVE_CYCLES)) u_props (.clk_i(clk_i), .rst_i(rst_i),
  .serial_clk_i(serial_clk_i), .serial_in_pin_i(serial_in_pin_i),
  .chip_sel_n_i(chip_sel_n_i), .write_protect_n_i(write_protect_n_i),
  .preset_reload_pin_n_i(preset_reload_pin_n_i), .serial_out_pin_o(serial_out_pin_o),
  .ready_o(ready_o), .read_power_o(read_power_o), .wiper0_o(wiper0_o), .wiper1_o(wiper1_o));
`default_nettype wire
